// ### bcp_pkg.sv
// constants for the step-up converter gate pwm control block
package bcp_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int CLK_MHZ       = 50;
    localparam int OSC_MHZ       = 8;
    // internal divider: code 1 gives 38 osc ticks (~210 kHz), code 31 gives 8 (1 MHz)
    localparam int FREQ_DIV_BASE = 39;
    localparam logic [4:0] FREQ_OFF = 5'h00;
    // target code: code 0 is 11 V, code 127 about 64.1 V
    localparam int TARGET_MIN_MV = 11000;
    localparam int TARGET_MAX_MV = 64100;
    localparam logic [8:0] MAX_LEVEL_CODE = 9'h08F;
    localparam logic [6:0] FB_LOW_CODE    = 7'h00;
    // current path codes, 1 lsb = 10 mV at the sense pins
    localparam int SENSE_LSB_MV   = 10;
    localparam int SENSE_OFFS_MV  = 500;
    localparam logic [11:0] SENSE_OFFS_CODE = 12'(SENSE_OFFS_MV / SENSE_LSB_MV);
    localparam int COMP_DIVIDER   = 7;
    localparam int LIM0_MV = 200;
    localparam int LIM1_MV = 300;
    localparam int LIM2_MV = 400;
    localparam int LIM3_MV = 500;
    // minimum on and off times in ns, rounded up to clock cycles
    localparam int TON0_NS  = 100;
    localparam int TON1_NS  = 150;
    localparam int TON2_NS  = 200;
    localparam int TON3_NS  = 300;
    localparam int TOFF0_NS = 100;
    localparam int TOFF1_NS = 200;
    localparam int TOFF2_NS = 300;
    localparam int TOFF3_NS = 400;
    localparam int TON0_CYC  = (TON0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TON1_CYC  = (TON1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TON2_CYC  = (TON2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TON3_CYC  = (TON3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOFF0_CYC = (TOFF0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOFF1_CYC = (TOFF1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOFF2_CYC = (TOFF2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOFF3_CYC = (TOFF3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] PERIOD_UNKNOWN = 16'hFFFF;
    typedef enum logic {ST_IDLE, ST_ON} bcp_state_t;
endpackage

// ### bcp_pwm_ctrl.sv
// gate pwm control for a current-mode step-up converter
//
// Behaviour
// RULE1: target chosen by 7-bit code, code 0 is 11 V, top about 64.1 V.
// RULE2: after power-up converter disabled and target code zero.
// RULE3: above target plus margin: gate off, overvoltage flag set, running cleared.
// RULE4: restart only below margin minus hysteresis; running flag returns then.
// RULE5: overvoltage flag latched; read while below reactivation level clears it.
// RULE6: overvoltage flag may read set on first read after power-on.
// RULE7: overvoltage detection stays active while converter disabled.
// RULE8: optional variant treats too-low feedback as overvoltage.
// RULE9: gate off when sense plus 0.5 V offset plus ramp reaches comp/7.
// RULE10: 2-bit slope select, one setting disables the ramp.
// RULE11: gate off each cycle when sense reaches selected current limit.
// RULE12: source bit: 0 internal timing, 1 external sync pin.
// RULE13: pwm only while enable is 1; gate held off otherwise.
// RULE14: controller zeroes error amp gain when disabling converter.
// RULE15: internal 5-bit frequency select from 8 MHz osc; code 0 stops.
// RULE16: sync pin sampled and each edge debounced over two cycles.
// RULE17: edge invert bit: 0 rising edges, 1 falling edges.
// RULE18: any pulse lasts at least min on-time; no demand gives no pulse. Code: hard_stop or a new period start ends a pulse sooner.
// RULE19: gate low at least min off-time each period.
// RULE20: controller avoids min off-time too large for low battery.
// RULE21: converter starts on enable 0-to-1, stops on 1-to-0.
// RULE22: converter held off when target plus margin exceeds trimmed maximum.
// RULE23: each period starts with gate high at tick or qualified sync edge.
`timescale 1ns/100ps
module bcp_pwm_ctrl #(
    parameter bit FB_LOSS_DETECT = 1'b0
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       converter_enable,
    input  wire logic [6:0] output_target_code,
    input  wire logic [2:0] overvoltage_margin,
    input  wire logic [1:0] reactivation_hysteresis,
    input  wire logic [3:0] trimmed_limit_offset,
    input  wire logic [6:0] output_voltage_code,
    input  wire logic       overvoltage_flag_read,
    input  wire logic [1:0] slope_comp_select,
    input  wire logic [1:0] current_limit_threshold,
    input  wire logic [7:0] current_sense_input,
    input  wire logic [9:0] comp_level_code,
    input  wire logic       pwm_source_select,
    input  wire logic [4:0] internal_freq_select,
    input  wire logic       sync_pin,
    input  wire logic       sync_edge_invert,
    input  wire logic [1:0] min_on_time_select,
    input  wire logic [1:0] min_off_time_select,
    output logic            gate_drive,
    output logic            running_flag,
    output logic            overvoltage_flag
);
    import bcp_pkg::*;

    function automatic logic [7:0] sel4(input logic [1:0] s, input int a, input int b,
                                        input int c, input int d);
        unique case (s)
            2'd0: sel4 = 8'(a);
            2'd1: sel4 = 8'(b);
            2'd2: sel4 = 8'(c);
            2'd3: sel4 = 8'(d);
        endcase
    endfunction

    logic [1:0] rst_sync_q;
    logic       rst_i_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_i_n = rst_sync_q[1];

    // voltage window comparisons
    logic [8:0] ov_level;
    logic [8:0] react_level;
    logic       ov_trip;
    logic       below_react;
    logic       limit_block;
    always_comb begin
        ov_level    = 9'(output_target_code) + 9'(overvoltage_margin);    // RULE1
        react_level = ov_level - 9'(reactivation_hysteresis);
        ov_trip     = (9'(output_voltage_code) > ov_level)                      // RULE3 RULE7
                    || (FB_LOSS_DETECT && output_voltage_code <= FB_LOW_CODE); // RULE8
        below_react = (9'(output_voltage_code) < react_level) && !ov_trip;     // RULE4
        limit_block = ov_level > (MAX_LEVEL_CODE - 9'(trimmed_limit_offset));  // RULE22
    end

    // enable edges, overvoltage block and flags
    logic en_prev_q, en_prev_d, conv_on_q, conv_on_d;
    logic ov_block_q, ov_block_d, ov_flag_q, ov_flag_d, running_q, running_d;
    logic run_ok;
    always_comb begin
        en_prev_d = converter_enable;
        conv_on_d = conv_on_q;
        if (converter_enable && !en_prev_q) begin
            conv_on_d = 1'b1;                                   // RULE21
        end else if (!converter_enable && en_prev_q) begin
            conv_on_d = 1'b0;                                   // RULE21
        end
        ov_block_d = ov_block_q;
        if (ov_trip) begin
            ov_block_d = 1'b1;                                  // RULE3
        end else if (below_react) begin
            ov_block_d = 1'b0;                                  // RULE4
        end
        // a new trip wins over a read in the same cycle
        ov_flag_d = ov_trip || (ov_flag_q && !(overvoltage_flag_read && below_react)); // RULE5
        run_ok    = conv_on_q && !ov_block_q && !limit_block && !ov_trip;
        running_d = conv_on_d && !ov_block_d && !limit_block;   // RULE3 RULE4 RULE22
    end
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            en_prev_q  <= 1'b0;
            conv_on_q  <= 1'b0;                                 // RULE2
            ov_block_q <= 1'b0;
            ov_flag_q  <= 1'b1;                                 // RULE6
            running_q  <= 1'b0;
        end else begin
            en_prev_q  <= en_prev_d;
            conv_on_q  <= conv_on_d;
            ov_block_q <= ov_block_d;
            ov_flag_q  <= ov_flag_d;
            running_q  <= running_d;
        end
    end

    // period tick: 8 MHz osc made from clk by fractional accumulator, then divided
    logic [5:0] osc_acc_q, osc_acc_d;
    logic [5:0] div_cnt_q, div_cnt_d;
    logic [5:0] div_len;
    logic       osc_tick, int_tick;
    // sync pin: three flops, level taken when the last two agree
    logic [2:0] sync_q, sync_d;
    logic       sync_lvl_q, sync_lvl_d, ext_edge;
    always_comb begin
        div_len  = 6'(FREQ_DIV_BASE) - 6'(internal_freq_select);
        osc_tick = (osc_acc_q + 6'(OSC_MHZ)) >= 6'(CLK_MHZ);
        osc_acc_d = osc_tick ? 6'(osc_acc_q + 6'(OSC_MHZ) - 6'(CLK_MHZ))
                             : 6'(osc_acc_q + 6'(OSC_MHZ));
        int_tick  = 1'b0;
        div_cnt_d = div_cnt_q;
        if (internal_freq_select == FREQ_OFF) begin
            div_cnt_d = '0;                                     // RULE15
        end else if (osc_tick) begin
            if (div_cnt_q >= div_len - 6'd1) begin
                div_cnt_d = '0;
                int_tick  = 1'b1;                               // RULE15
            end else begin
                div_cnt_d = div_cnt_q + 6'd1;
            end
        end
        sync_d     = {sync_q[1:0], sync_pin};
        sync_lvl_d = (sync_q[2] == sync_q[1]) ? sync_q[2] : sync_lvl_q; // RULE16
        ext_edge   = (sync_lvl_d != sync_lvl_q)
                   && (sync_lvl_d == !sync_edge_invert);        // RULE17
    end
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            osc_acc_q  <= '0;
            div_cnt_q  <= '0;
            sync_q     <= 3'b000;
            sync_lvl_q <= 1'b0;
        end else begin
            osc_acc_q  <= osc_acc_d;
            div_cnt_q  <= div_cnt_d;
            sync_q     <= sync_d;
            sync_lvl_q <= sync_lvl_d;
        end
    end

    // current comparators
    logic [7:0]  ton_min, toff_min, lim_code;
    logic [11:0] ramp, sense_sum, comp_ref;
    logic        cur_trip, limit_hit, period_start;
    logic [15:0] on_cnt_q, on_cnt_d, per_cnt_q, per_cnt_d, per_len_q, per_len_d;
    bcp_state_t  state_q, state_d;
    logic        gate_q, gate_d, hard_stop, duty_cap;
    always_comb begin
        ton_min  = sel4(min_on_time_select, TON0_CYC, TON1_CYC, TON2_CYC, TON3_CYC);
        toff_min = sel4(min_off_time_select, TOFF0_CYC, TOFF1_CYC, TOFF2_CYC, TOFF3_CYC);
        lim_code = sel4(current_limit_threshold, LIM0_MV / SENSE_LSB_MV,
                        LIM1_MV / SENSE_LSB_MV, LIM2_MV / SENSE_LSB_MV,
                        LIM3_MV / SENSE_LSB_MV);
        // slope select 0 leaves the ramp at zero
        ramp      = 12'(on_cnt_q[9:0] * 10'(slope_comp_select));               // RULE10
        sense_sum = 12'(current_sense_input) + SENSE_OFFS_CODE + ramp;
        comp_ref  = 12'(comp_level_code / 10'(COMP_DIVIDER));
        cur_trip  = sense_sum >= comp_ref;                                     // RULE9
        limit_hit = current_sense_input >= lim_code;                           // RULE11
        period_start = pwm_source_select ? ext_edge : int_tick;                // RULE12
        duty_cap  = (per_len_q != PERIOD_UNKNOWN)
                  && (17'(per_cnt_q) + 17'(toff_min) + 17'd1 >= 17'(per_len_q)); // RULE19
        // a falling enable must end the pulse at once, not one cycle late
        hard_stop = !run_ok || !conv_on_d || limit_hit || duty_cap;            // RULE11 RULE13
        per_cnt_d = (per_cnt_q == PERIOD_UNKNOWN) ? per_cnt_q : per_cnt_q + 16'd1;
        per_len_d = per_len_q;
        on_cnt_d  = on_cnt_q;
        state_d   = state_q;
        if (period_start) begin
            per_cnt_d = '0;
            per_len_d = per_cnt_q + 16'd1;
        end
        unique case (state_q)
            ST_IDLE: begin
                on_cnt_d = '0;
                // no pulse at all when there is no demand this period
                if (period_start && run_ok && !limit_hit && !cur_trip) begin
                    state_d = ST_ON;                            // RULE23 RULE18
                end
            end
            ST_ON: begin
                on_cnt_d = on_cnt_q + 16'd1;
                // protections cut short the minimum on-time; regulation does not
                if (hard_stop || period_start
                    || (cur_trip && on_cnt_q + 16'd1 >= 16'(ton_min))) begin // RULE18
                    state_d = ST_IDLE;                          // RULE9
                end
            end
        endcase
        gate_d = (state_d == ST_ON) && run_ok && conv_on_d;     // RULE13
    end
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            state_q   <= ST_IDLE;
            gate_q    <= 1'b0;
            on_cnt_q  <= '0;
            per_cnt_q <= '0;
            per_len_q <= PERIOD_UNKNOWN;
        end else begin
            state_q   <= state_d;
            gate_q    <= gate_d;
            on_cnt_q  <= on_cnt_d;
            per_cnt_q <= per_cnt_d;
            per_len_q <= per_len_d;
        end
    end

    assign gate_drive       = gate_q;
    assign running_flag     = running_q;
    assign overvoltage_flag = ov_flag_q;

    a_ov_gate_off: assert property (@(posedge clk) disable iff (!rst_i_n) // RULE3
        ov_trip |=> !gate_q && ov_flag_q && !running_q)
        else $error("gate or flags wrong after overvoltage trip");
    a_ov_hold_block: assert property (@(posedge clk) disable iff (!rst_i_n) // RULE4
        ov_block_q && !below_react |=> !running_q && !gate_q)
        else $error("restarted before reactivation level");
    a_ov_flag_clear: assert property (@(posedge clk) disable iff (!rst_i_n) // RULE5
        $fell(ov_flag_q) |-> $past(overvoltage_flag_read) && $past(below_react))
        else $error("overvoltage flag cleared without qualified read");
    a_ov_disabled: assert property (@(posedge clk) disable iff (!rst_i_n) // RULE7
        !conv_on_q && ov_trip |=> ov_flag_q)
        else $error("overvoltage not flagged while disabled");
    a_limit_gate: assert property (@(posedge clk) disable iff (!rst_i_n) // RULE11
        gate_q && limit_hit |=> !gate_q)
        else $error("gate stayed on at current limit");
    a_enable_gate: assert property (@(posedge clk) disable iff (!rst_i_n) // RULE13
        !converter_enable ##1 !converter_enable |=> !gate_q)
        else $error("gate driven while disabled");
    a_freq_stop: assert property (@(posedge clk) disable iff (!rst_i_n) // RULE15
        internal_freq_select == FREQ_OFF && !pwm_source_select
        |-> !int_tick ##1 !$rose(gate_q))
        else $error("internal tick while frequency code zero");
    a_sync_edge: assert property (@(posedge clk) disable iff (!rst_i_n) // RULE16
        ext_edge |-> sync_q[2] == sync_q[1] && sync_lvl_q != sync_q[2])
        else $error("sync edge taken without debounce");
    a_min_on: assert property (@(posedge clk) disable iff (!rst_i_n) // RULE18
        $fell(gate_q) && !$past(hard_stop) && !$past(period_start)
        |-> $past(on_cnt_q) + 16'd1 >= 16'(ton_min))
        else $error("pulse shorter than minimum on-time");
    a_trim_block: assert property (@(posedge clk) disable iff (!rst_i_n) // RULE22
        limit_block |=> !running_q && !gate_q)
        else $error("converter ran above trimmed maximum");
    a_start_gate: assert property (@(posedge clk) disable iff (!rst_i_n) // RULE23
        $rose(gate_q) |-> $past(period_start))
        else $error("gate rose away from period start");
endmodule // bcp_pwm_ctrl

// ### bcp_sync_model.sv
// external sync source standing on the far side of the sync pin
`timescale 1ns/100ps
module bcp_sync_model #(
    parameter int HALF_NS = 608
) (
    input  wire logic run,
    output logic      sync_pin
);
    initial sync_pin = 1'b0;
    // every multiple of 608 ns stays off the rising clock edges at 10 mod 20 ns
    // pin stands still while not running
    always begin
        #(HALF_NS);
        if (run) begin
            sync_pin = ~sync_pin;
        end
    end
endmodule // bcp_sync_model

// ### boost_converter_pwm_control_bench.sv
// self-checking bench for the gate pwm control block
`timescale 1ns/100ps
module boost_converter_pwm_control_bench;
    import bcp_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, rd = 1'b0, src = 1'b0, inv = 1'b0, run = 1'b0;
    logic [6:0] tgt = 7'h0a, vout = 7'h05;
    logic [2:0] marg = 3'h2;
    logic [1:0] hyst = 2'h1, slope = 2'h3, lim = 2'h3, ton = 2'h0, toff = 2'h0;
    logic [3:0] offs = 4'h0;
    logic [7:0] sense = 8'h00;
    logic [9:0] comp = 10'h1a4;
    logic [4:0] freq = 5'h1f;
    logic sync_pin, gate_drive, running_flag, overvoltage_flag;
    int error_cnt = 0, comparisons = 0, n;
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    bcp_sync_model u_sync (.run(run), .sync_pin(sync_pin));
    bcp_pwm_ctrl u_dut (
        .clk(clk), .rst_n(rst_n), .converter_enable(en), .output_target_code(tgt),
        .overvoltage_margin(marg), .reactivation_hysteresis(hyst),
        .trimmed_limit_offset(offs), .output_voltage_code(vout),
        .overvoltage_flag_read(rd), .slope_comp_select(slope),
        .current_limit_threshold(lim), .current_sense_input(sense),
        .comp_level_code(comp), .pwm_source_select(src), .internal_freq_select(freq),
        .sync_pin(sync_pin), .sync_edge_invert(inv), .min_on_time_select(ton),
        .min_off_time_select(toff), .gate_drive(gate_drive),
        .running_flag(running_flag), .overvoltage_flag(overvoltage_flag));
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic wait_gate(input logic v, input int lim_c, output int k);
        k = 0;
        while (gate_drive !== v && k < lim_c) begin
            tick(1);
            k++;
        end
    endtask
    task automatic count_high(input int k, output int c);
        c = 0;
        repeat (k) begin
            tick(1);
            if (gate_drive === 1'b1) c++;
        end
    endtask
    // width of the next whole pulse
    task automatic pulse_len(output int w);
        wait_gate(1'b0, 200, w);
        wait_gate(1'b1, 200, w);
        wait_gate(1'b0, 200, w);
    endtask
    task automatic read_flag();
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        tick(1);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #(CLK_PERIOD_NS * 20000);
        error_cnt++;
        results();
    end
    initial begin
        tick(12);
        check("gate_in_reset", gate_drive, 1'b0);
        check("run_in_reset", running_flag, 1'b0);
        check("ov_in_reset", overvoltage_flag, 1'b1);
        rst_n = 1'b1;
        tick(3);
        read_flag();
        check("ov_first_read", overvoltage_flag, 1'b0);
        $display("test reset done");
        tgt = 7'h7f; marg = 3'h7; offs = 4'hf;
        tick(2);
        en = 1'b1;
        tick(6);
        check("limit_block", running_flag, 1'b0);
        en = 1'b0; tgt = 7'h0a; marg = 3'h2; offs = 4'h0; freq = FREQ_OFF;
        tick(3);
        en = 1'b1;
        tick(3);
        check("run_on_rise", running_flag, 1'b1);
        count_high(150, n);
        check("freq_off", 16'(n), 16'h0000);
        freq = 5'h1f;
        pulse_len(n);
        check("ramp_pulse", 16'(n >= TON0_CYC && n <= TON0_CYC + 2), 1'b1);
        slope = 2'h0;
        pulse_len(n);
        pulse_len(n);
        check("cap_toff0", 16'(n >= 20 && n <= 50 - TOFF0_CYC), 1'b1);
        toff = 2'h3; // large enough to cap the pulse at 30 of the 50 cycles
        pulse_len(n);
        pulse_len(n);
        check("cap_toff3", 16'(n >= 10 && n <= 50 - TOFF3_CYC), 1'b1);
        slope = 2'h3; toff = 2'h0; comp = 10'h3ff;
        // comparator alone would let these pulses through, only the limit stops them
        wait_gate(1'b1, 200, n);
        sense = 8'h3c;
        tick(1);
        check("cur_limit_cut", gate_drive, 1'b0);
        count_high(150, n);
        check("cur_limit", 16'(n), 16'h0000);
        sense = 8'h00; comp = 10'h000;
        count_high(150, n);
        check("no_demand", 16'(n), 16'h0000);
        comp = 10'h1a4;
        $display("test pwm done");
        vout = 7'h0c;
        tick(2);
        check("ov_at_level", overvoltage_flag, 1'b0);
        vout = 7'h0d;
        tick(2);
        check("ov_gate", gate_drive, 1'b0);
        check("ov_flag", overvoltage_flag, 1'b1);
        check("ov_run", running_flag, 1'b0);
        read_flag();
        check("ov_read_high", overvoltage_flag, 1'b1);
        vout = 7'h0b;
        count_high(120, n);
        check("ov_hold_gate", 16'(n), 16'h0000);
        check("ov_hold_run", running_flag, 1'b0);
        vout = 7'h0a;
        tick(3);
        check("ov_restart", running_flag, 1'b1);
        check("ov_latched", overvoltage_flag, 1'b1);
        read_flag();
        check("ov_cleared", overvoltage_flag, 1'b0);
        $display("test overvoltage done");
        en = 1'b0; // controller would zero the amplifier gain here
        tick(3);
        check("run_off", running_flag, 1'b0);
        count_high(120, n);
        check("gate_off", 16'(n), 16'h0000);
        vout = 7'h0d;
        tick(3);
        check("ov_disabled", overvoltage_flag, 1'b1);
        vout = 7'h05;
        read_flag();
        en = 1'b1; src = 1'b1; run = 1'b1;
        $display("test disable done");
        for (int i = 0; i < 2; i++) begin
            inv = i[0];
            tick(80);
            if (i == 0) @(posedge sync_pin);
            else @(negedge sync_pin);
            tick(1);
            wait_gate(1'b1, 14, n);
            check("sync_edge", 16'(n >= 2 && n <= 9), 1'b1);
            if (i == 0) @(negedge sync_pin);
            else @(posedge sync_pin);
            count_high(14, n);
            check("sync_other", 16'(n), 16'h0000);
        end
        $display("test sync done");
        results();
    end
endmodule // boost_converter_pwm_control_bench
